// ==== pwm_pkg.sv ====
package pwm_pkg;
  // Special function register addresses
  localparam logic [7:0] mode_ctrl_addr  = 8'hd9;
  localparam logic [7:0] mode_ctrl_reset = 8'h40;
  // Mode control fields
  localparam int idle_bit     = 7;
  localparam int wdog_en_bit  = 6;
  localparam int wdog_lck_bit = 5;
  localparam int tb_sel_hi    = 3;
  localparam int tb_sel_lo    = 1;
  localparam int ovf_ie_bit   = 0;
  localparam int unused_bit   = 4;
  // Module mode register fields
  localparam int cmp_en_bit   = 6;
  localparam int pwm_en_bit   = 1;
  localparam logic [7:0] module_mode_reset = 8'h00;
  // Timebase codes
  localparam logic [2:0] tb_div12 = 3'h0;
  localparam logic [2:0] tb_div4  = 3'h1;
  localparam logic [2:0] tb_t0ovf = 3'h2;
  localparam logic [2:0] tb_ext   = 3'h3;
  localparam logic [2:0] tb_sys   = 3'h4;
  localparam logic [2:0] tb_osc8  = 3'h5;
  // Prescale terminal counts
  localparam logic [3:0] div12_last = 4'hb;
  localparam logic [3:0] div4_last  = 4'h3;
  localparam logic [3:0] div8_last  = 4'h7;
  localparam logic [7:0] byte_max   = 8'hff;
endpackage : pwm_pkg

// ==== edge_sync.sv ====
`timescale 1ns/1ps
// Three-stage synchroniser; a change counts once stages two and three agree
module edge_sync (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic async_in,
  output logic      fall_pulse
);
  logic [2:0] stage;
  logic       stable;

  // Stage one only feeds stage two
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stage <= 3'h0;
    end else begin
      stage <= {stage[1:0], async_in};
    end
  end

  // Settled level, updated only on agreement
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stable <= 1'b0;
    end else if (stage[1] == stage[2]) begin
      stable <= stage[2];
    end
  end

  // One-cycle pulse on a settled high-to-low change
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fall_pulse <= 1'b0;
    end else begin
      fall_pulse <= stable && (stage[1] == stage[2]) && !stage[2];
    end
  end
endmodule : edge_sync

// ==== pwm_module.sv ====
`timescale 1ns/1ps
// One capture/compare channel in 8-bit PWM mode
module pwm_module #(
  parameter logic [7:0] mode_addr = 8'hda,
  parameter logic [7:0] low_addr  = 8'he9,
  parameter logic [7:0] high_addr = 8'hf9
) (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       tick,
  input  wire logic [7:0] counter_low_byte,
  output logic [7:0]      module_mode_register,
  output logic [7:0]      compare_low_byte,
  output logic [7:0]      compare_high_byte,
  output logic            module_output_pin
);
  logic       wrap;
  logic       pwm_mode;
  logic [7:0] next_count;
  assign wrap       = tick && (counter_low_byte == pwm_pkg::byte_max);
  // Count entered at this tick; matching on it keeps the pin in step with the count
  assign next_count = counter_low_byte + 8'h01;
  // Both enables needed for PWM
  assign pwm_mode = module_mode_register[pwm_pkg::cmp_en_bit] &&
                    module_mode_register[pwm_pkg::pwm_en_bit];

  // Mode register; compare writes move the comparator enable
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      module_mode_register <= pwm_pkg::module_mode_reset;
    end else if (wr_en && wr_addr == mode_addr) begin
      module_mode_register <= wr_data;
    end else if (wr_en && wr_addr == low_addr) begin
      module_mode_register[pwm_pkg::cmp_en_bit] <= 1'b0;
    end else if (wr_en && wr_addr == high_addr) begin
      module_mode_register[pwm_pkg::cmp_en_bit] <= 1'b1;
    end
  end

  // High byte is software's alone
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      compare_high_byte <= 8'h00;
    end else if (wr_en && wr_addr == high_addr) begin
      compare_high_byte <= wr_data;
    end
  end

  // Low byte reloads from high at every wrap in PWM mode; software write wins
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      compare_low_byte <= 8'h00;
    end else if (wr_en && wr_addr == low_addr) begin
      compare_low_byte <= wr_data;
    end else if (wrap && pwm_mode) begin
      compare_low_byte <= compare_high_byte;
    end
  end

  // Pin moves on the same tick as the count, so full-rate duty is exact; zero keeps it high
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      module_output_pin <= 1'b0;
    end else if (!module_mode_register[pwm_pkg::cmp_en_bit]) begin
      module_output_pin <= 1'b0;
    end else if (pwm_mode && wrap) begin
      module_output_pin <= (compare_high_byte == 8'h00);
    end else if (pwm_mode && tick && next_count == compare_low_byte) begin
      module_output_pin <= 1'b1;
    end
  end

  property p_low_write_clears;
    @(posedge clock) disable iff (!rst_b)
      (wr_en && wr_addr == low_addr) |=> !module_mode_register[pwm_pkg::cmp_en_bit];
  endproperty
  a_low_write_clears: assert property (p_low_write_clears) else $error("cmp enable kept");

  property p_high_write_sets;
    @(posedge clock) disable iff (!rst_b)
      (wr_en && wr_addr == high_addr) |=> module_mode_register[pwm_pkg::cmp_en_bit];
  endproperty
  a_high_write_sets: assert property (p_high_write_sets) else $error("cmp enable not set");

  property p_reload;
    @(posedge clock) disable iff (!rst_b)
      (wrap && pwm_mode && !(wr_en && wr_addr == low_addr))
      |=> compare_low_byte == $past(compare_high_byte);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload at wrap");

  property p_off_low;
    @(posedge clock) disable iff (!rst_b)
      !module_mode_register[pwm_pkg::cmp_en_bit] |=> !module_output_pin;
  endproperty
  a_off_low: assert property (p_off_low) else $error("pin high while off");

  sequence s_match;
    pwm_mode && tick && !wrap && next_count == compare_low_byte;
  endsequence
  property p_set_on_match;
    @(posedge clock) disable iff (!rst_b)
      s_match |=> module_output_pin;
  endproperty
  a_set_on_match: assert property (p_set_on_match) else $error("pin not set");

  property p_clear_on_wrap;
    @(posedge clock) disable iff (!rst_b)
      (pwm_mode && wrap && compare_high_byte != 8'h00) |=> !module_output_pin;
  endproperty
  a_clear_on_wrap: assert property (p_clear_on_wrap) else $error("pin not cleared");

  property p_full_duty;
    @(posedge clock) disable iff (!rst_b)
      (pwm_mode && wrap && compare_high_byte == 8'h00) |=> module_output_pin;
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("full duty broken");
endmodule : pwm_module

// ==== counter_array_8bit_pwm.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Each module makes its own PWM on its own pin, sharing the counter.
// - PWM period is one full wrap of the counter low byte.
// - Pin goes high when counter low byte equals compare low byte.
// - Pin goes low when counter low byte overflows.
// - On wrap, compare high byte is copied into compare low byte.
// - PWM mode needs comparator enable and PWM enable both set.
// - Writing compare low byte clears comparator enable.
// - Writing compare high byte sets comparator enable.
// - Duty is (256 - high byte)/256; zero means always high.
// - Comparator enable clear holds the pin low.
// - Watchdog enable bit selects module 2 as watchdog; set at reset.
// - Once locked, watchdog enable cannot be cleared until reset.
module counter_array_8bit_pwm #(
  parameter int n_modules = 3
) (
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  input  wire logic                 sfr_wr,
  input  wire logic [7:0]           sfr_addr,
  input  wire logic [7:0]           sfr_wdata,
  input  wire logic                 cpu_idle,
  input  wire logic                 timer0_overflow,
  input  wire logic                 external_count_input,
  input  wire logic                 ext_osc_clock,
  input  wire logic                 overflow_flag_clear,
  output logic [7:0]                counter_mode_control,
  output logic [7:0]                counter_low_byte,
  output logic                      counter_overflow_flag,
  output logic                      overflow_irq,
  output logic                      watchdog_active,
  output logic [n_modules-1:0]      module_output_pin
);
  logic       eci_fall;
  logic       osc_fall;
  logic [3:0] prescale;
  logic [3:0] osc_count;
  logic       tick;
  logic [2:0] tb_sel;
  logic       lock_hit;
  logic       lock;
  logic [7:0] counter_high_byte;
  logic       idle_hold;
  logic       full_wrap;

  assign tb_sel = counter_mode_control[pwm_pkg::tb_sel_hi:pwm_pkg::tb_sel_lo];
  assign lock   = counter_mode_control[pwm_pkg::wdog_lck_bit];

  // Terms for the checks below; kept apart so the checks do not copy the count logic
  assign idle_hold = cpu_idle && counter_mode_control[pwm_pkg::idle_bit];
  assign full_wrap = tick && counter_low_byte == pwm_pkg::byte_max &&
                     counter_high_byte == pwm_pkg::byte_max;

  edge_sync u_eci_sync (
    .clock      (clock),
    .rst_b      (rst_b),
    .async_in   (external_count_input),
    .fall_pulse (eci_fall)
  );

  edge_sync u_osc_sync (
    .clock      (clock),
    .rst_b      (rst_b),
    .async_in   (ext_osc_clock),
    .fall_pulse (osc_fall)
  );

  // Mode control; a locked watchdog enable stays set until reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      counter_mode_control <= pwm_pkg::mode_ctrl_reset;
    end else if (sfr_wr && sfr_addr == pwm_pkg::mode_ctrl_addr) begin
      counter_mode_control        <= sfr_wdata;
      counter_mode_control[pwm_pkg::unused_bit] <= 1'b0;
      if (lock) begin
        counter_mode_control[pwm_pkg::wdog_en_bit]  <= 1'b1;
        counter_mode_control[pwm_pkg::wdog_lck_bit] <= 1'b1;
      end
    end
  end

  // System clock prescaler, free running
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prescale <= 4'h0;
    end else if ((tb_sel == pwm_pkg::tb_div12 && prescale == pwm_pkg::div12_last) ||
                 (tb_sel == pwm_pkg::tb_div4 && prescale == pwm_pkg::div4_last)) begin
      prescale <= 4'h0;
    end else begin
      prescale <= prescale + 4'h1;
    end
  end

  // External oscillator divided by eight
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      osc_count <= 4'h0;
    end else if (osc_fall) begin
      osc_count <= (osc_count == pwm_pkg::div8_last) ? 4'h0 : osc_count + 4'h1;
    end
  end

  // Count enable from the selected timebase; reserved codes never count
  always_comb begin
    case (tb_sel)
      pwm_pkg::tb_div12: tick = (prescale == pwm_pkg::div12_last);
      pwm_pkg::tb_div4:  tick = (prescale == pwm_pkg::div4_last);
      pwm_pkg::tb_t0ovf: tick = timer0_overflow;
      pwm_pkg::tb_ext:   tick = eci_fall;
      pwm_pkg::tb_sys:   tick = 1'b1;
      pwm_pkg::tb_osc8:  tick = osc_fall && (osc_count == pwm_pkg::div8_last);
      default:           tick = 1'b0;
    endcase
    if (cpu_idle && counter_mode_control[pwm_pkg::idle_bit]) begin
      tick = 1'b0;
    end
  end

  // Shared 16-bit counter; low byte wrap paces every PWM period
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      counter_low_byte  <= 8'h00;
      counter_high_byte <= 8'h00;
    end else if (tick) begin
      counter_low_byte <= counter_low_byte + 8'h01;
      if (counter_low_byte == pwm_pkg::byte_max) begin
        counter_high_byte <= counter_high_byte + 8'h01;
      end
    end
  end

  // Overflow flag: a new overflow beats a same-cycle clear
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      counter_overflow_flag <= 1'b0;
    end else if (tick && counter_low_byte == pwm_pkg::byte_max &&
                 counter_high_byte == pwm_pkg::byte_max) begin
      counter_overflow_flag <= 1'b1;
    end else if (overflow_flag_clear) begin
      counter_overflow_flag <= 1'b0;
    end
  end

  // Registered request, one cycle behind the flag
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      overflow_irq <= 1'b0;
    end else begin
      overflow_irq <= counter_overflow_flag &&
                      counter_mode_control[pwm_pkg::ovf_ie_bit];
    end
  end

  // Module 2 is claimed as watchdog while enabled
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_active <= 1'b0;
    end else begin
      watchdog_active <= counter_mode_control[pwm_pkg::wdog_en_bit];
    end
  end

  // Independent channels on the shared counter
  genvar gi;
  generate
    for (gi = 0; gi < n_modules; gi++) begin : g_mod
      pwm_module #(
        .mode_addr (8'(8'hda + gi)),
        .low_addr  (8'(8'he9 + 2 * gi)),
        .high_addr (8'(8'hea + 2 * gi))
      ) u_mod (
        .clock                (clock),
        .rst_b                (rst_b),
        .wr_en                (sfr_wr),
        .wr_addr              (sfr_addr),
        .wr_data              (sfr_wdata),
        .tick                 (tick),
        .counter_low_byte     (counter_low_byte),
        .module_mode_register (),
        .compare_low_byte     (),
        .compare_high_byte    (),
        .module_output_pin    (module_output_pin[gi])
      );
    end
  endgenerate

  property p_lock_holds;
    @(posedge clock) disable iff (!rst_b)
      lock |=> counter_mode_control[pwm_pkg::wdog_en_bit] && lock;
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("lock lost");

  property p_irq;
    @(posedge clock) disable iff (!rst_b)
      (counter_overflow_flag && counter_mode_control[pwm_pkg::ovf_ie_bit]) |=> overflow_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_idle_stops;
    @(posedge clock) disable iff (!rst_b)
      (cpu_idle && counter_mode_control[pwm_pkg::idle_bit]) |=> $stable(counter_low_byte);
  endproperty
  a_idle_stops: assert property (p_idle_stops) else $error("counted in idle");

  property p_sys_counts;
    @(posedge clock) disable iff (!rst_b)
      (tb_sel == pwm_pkg::tb_sys && !cpu_idle) |=> counter_low_byte == $past(counter_low_byte) + 8'h01;
  endproperty
  a_sys_counts: assert property (p_sys_counts) else $error("no count");

  // Register bits that hardware cannot move on its own
  property p_unused_zero;
    @(posedge clock) disable iff (!rst_b)
      !counter_mode_control[pwm_pkg::unused_bit];
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

  property p_write_only;
    @(posedge clock) disable iff (!rst_b)
      !(sfr_wr && sfr_addr == pwm_pkg::mode_ctrl_addr) |=> $stable(counter_mode_control);
  endproperty
  a_write_only: assert property (p_write_only) else $error("mode moved without write");

  property p_wdog_follow;
    @(posedge clock) disable iff (!rst_b)
      1'b1 |=> watchdog_active == $past(counter_mode_control[pwm_pkg::wdog_en_bit]);
  endproperty
  a_wdog_follow: assert property (p_wdog_follow) else $error("watchdog copy stale");

  property p_irq_masked;
    @(posedge clock) disable iff (!rst_b)
      !counter_mode_control[pwm_pkg::ovf_ie_bit] |=> !overflow_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq while masked");

  // Overflow flag: a wrap in the clear cycle must still be seen
  sequence s_full_wrap;
    full_wrap;
  endsequence
  property p_set_wins;
    @(posedge clock) disable iff (!rst_b)
      s_full_wrap |=> counter_overflow_flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("overflow missed");

  property p_flag_clear;
    @(posedge clock) disable iff (!rst_b)
      (overflow_flag_clear && !full_wrap) |=> !counter_overflow_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_carry;
    @(posedge clock) disable iff (!rst_b)
      (tick && counter_low_byte == pwm_pkg::byte_max)
      |=> counter_high_byte == $past(counter_high_byte) + 8'h01;
  endproperty
  a_carry: assert property (p_carry) else $error("no carry into high byte");

  // Counter pacing per timebase; a miss here skews every PWM period
  sequence s_step;
    counter_low_byte == $past(counter_low_byte) + 8'h01;
  endsequence

  property p_no_tick_holds;
    @(posedge clock) disable iff (!rst_b)
      !tick |=> $stable(counter_low_byte);
  endproperty
  a_no_tick_holds: assert property (p_no_tick_holds) else $error("count without tick");

  property p_reserved_halt;
    @(posedge clock) disable iff (!rst_b)
      (tb_sel > pwm_pkg::tb_osc8) |=> $stable(counter_low_byte);
  endproperty
  a_reserved_halt: assert property (p_reserved_halt) else $error("reserved code counts");

  property p_div12_counts;
    @(posedge clock) disable iff (!rst_b)
      (tb_sel == pwm_pkg::tb_div12 && prescale == pwm_pkg::div12_last && !idle_hold)
      |=> s_step;
  endproperty
  a_div12_counts: assert property (p_div12_counts) else $error("div12 tick lost");

  property p_div4_counts;
    @(posedge clock) disable iff (!rst_b)
      (tb_sel == pwm_pkg::tb_div4 && prescale == pwm_pkg::div4_last && !idle_hold)
      |=> s_step;
  endproperty
  a_div4_counts: assert property (p_div4_counts) else $error("div4 tick lost");

  property p_t0_counts;
    @(posedge clock) disable iff (!rst_b)
      (tb_sel == pwm_pkg::tb_t0ovf && timer0_overflow && !idle_hold) |=> s_step;
  endproperty
  a_t0_counts: assert property (p_t0_counts) else $error("timer0 tick lost");

  property p_ext_counts;
    @(posedge clock) disable iff (!rst_b)
      (tb_sel == pwm_pkg::tb_ext && eci_fall && !idle_hold) |=> s_step;
  endproperty
  a_ext_counts: assert property (p_ext_counts) else $error("external edge lost");

  property p_osc_counts;
    @(posedge clock) disable iff (!rst_b)
      (tb_sel == pwm_pkg::tb_osc8 && osc_fall && osc_count == pwm_pkg::div8_last && !idle_hold)
      |=> s_step;
  endproperty
  a_osc_counts: assert property (p_osc_counts) else $error("osc tick lost");

  property p_idle_runs;
    @(posedge clock) disable iff (!rst_b)
      (cpu_idle && !counter_mode_control[pwm_pkg::idle_bit] && tb_sel == pwm_pkg::tb_sys)
      |=> s_step;
  endproperty
  a_idle_runs: assert property (p_idle_runs) else $error("stopped in idle");
endmodule : counter_array_8bit_pwm

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic       clock;
  logic       rst_b;
  logic       sfr_wr;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic       cpu_idle;
  logic       timer0_overflow;
  logic       external_count_input;
  logic       ext_osc_clock;
  logic       overflow_flag_clear;
  logic [7:0] counter_mode_control;
  logic [7:0] counter_low_byte;
  logic       counter_overflow_flag;
  logic       overflow_irq;
  logic       watchdog_active;
  logic [2:0] module_output_pin;
  int         num_errors;
  int         n_checks;
  int         cycles;
  int         cnt [3];

  counter_array_8bit_pwm #(.n_modules(3)) i_counter_array_8bit_pwm (
    .clock                 (clock),
    .rst_b                 (rst_b),
    .sfr_wr                (sfr_wr),
    .sfr_addr              (sfr_addr),
    .sfr_wdata             (sfr_wdata),
    .cpu_idle              (cpu_idle),
    .timer0_overflow       (timer0_overflow),
    .external_count_input  (external_count_input),
    .ext_osc_clock         (ext_osc_clock),
    .overflow_flag_clear   (overflow_flag_clear),
    .counter_mode_control  (counter_mode_control),
    .counter_low_byte      (counter_low_byte),
    .counter_overflow_flag (counter_overflow_flag),
    .overflow_irq          (overflow_irq),
    .watchdog_active       (watchdog_active),
    .module_output_pin     (module_output_pin)
  );

  // Free-running system clock, 50 ns period
  always #25 clock = ~clock;

  // Hang guard; the overflow wait dominates the run
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      num_errors++;
      $display("[ERR] %0t timeout", $time);
      conclude();
    end
  end

  task conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  // Inputs always move 1 ns after the rising edge
  task step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One write per call; idle cycle after so the strobe never re-rises in one step
  task wr(input logic [7:0] a, input logic [7:0] d);
    sfr_wr    = 1'b1;
    sfr_addr  = a;
    sfr_wdata = d;
    step(1);
    sfr_wr = 1'b0;
    step(1);
  endtask : wr

  // Counter advance over 96 cycles with all count sources toggling at once
  task rate(input logic [2:0] code, input int exp, input int tol);
    logic [7:0] start;
    logic [7:0] d;
    wr(pwm_pkg::mode_ctrl_addr, {4'h0, code, 1'b0});
    step(16);
    start = counter_low_byte;
    for (int i = 0; i < 96; i++) begin
      timer0_overflow      = (i % 8 == 0);
      external_count_input = ((i / 4) % 2 == 0);
      ext_osc_clock        = ((i / 2) % 2 == 0);
      step(1);
    end
    timer0_overflow = 1'b0;
    d = counter_low_byte - start;
    n_checks++;
    if ($isunknown(d) || int'(d) < exp - tol || int'(d) > exp + tol) begin
      num_errors++;
      $display("[ERR] %0t timebase %0d advanced %0d exp %0d", $time, code, d, exp);
    end
  endtask : rate

  // High cycles of each pin over exactly one period
  task measure();
    cnt = '{0, 0, 0};
    repeat (256) begin
      for (int k = 0; k < 3; k++) if (module_output_pin[k] === 1'b1) cnt[k]++;
      step(1);
    end
  endtask : measure

  // Load all three modules, low byte first, then check duty
  task duty(input logic [7:0] h0, input logic [7:0] h1, input logic [7:0] h2);
    logic [7:0] h [3];
    h = '{h0, h1, h2};
    for (int k = 0; k < 3; k++) begin
      wr(8'hda + 8'(k), 8'h42);
      wr(8'he9 + 8'(2 * k), h[k]);
      wr(8'hea + 8'(2 * k), h[k]);
    end
    step(520);
    measure();
    for (int k = 0; k < 3; k++) chk(16'(cnt[k]), 16'd256 - {8'h00, h[k]}, "duty");
  endtask : duty

  initial begin
    clock = 0; rst_b = 0; sfr_wr = 0; sfr_addr = 8'h00; sfr_wdata = 8'h00;
    cpu_idle = 0; timer0_overflow = 0; external_count_input = 1;
    ext_osc_clock = 0; overflow_flag_clear = 0;
    num_errors = 0; n_checks = 0; cycles = 0;
    step(10);
    rst_b = 1;
    step(3);
    chk({8'h00, counter_mode_control}, {8'h00, pwm_pkg::mode_ctrl_reset}, "mode reset");
    chk({15'h0, watchdog_active}, 16'h0001, "watchdog at reset");
    chk({13'h0, module_output_pin}, 16'h0000, "pins at reset");
    // Every timebase code, reserved ones included
    rate(pwm_pkg::tb_div12, 96 / 12, 1);
    chk({15'h0, watchdog_active}, 16'h0000, "watchdog cleared");
    rate(pwm_pkg::tb_div4, 96 / 4, 1);
    rate(pwm_pkg::tb_t0ovf, 96 / 8, 1);
    rate(pwm_pkg::tb_ext, 96 / 8, 1);
    rate(pwm_pkg::tb_osc8, 96 / 4 / 8, 1);
    rate(3'h6, 0, 0);
    rate(3'h7, 0, 0);
    rate(pwm_pkg::tb_sys, 96, 1);
    // Unused bit reads zero, unknown address ignored
    wr(pwm_pkg::mode_ctrl_addr, 8'h18);
    wr(8'hd8, 8'hff);
    chk({8'h00, counter_mode_control}, 16'h0008, "mode write");
    // Three independent duties on the shared counter, boundaries included
    duty(8'h00, 8'h80, 8'hff);
    duty(8'h40, 8'hc0, 8'h01);
    // Low byte write alone drops comparator enable: pin stays low
    wr(8'he9, 8'h10);
    step(300);
    measure();
    chk(16'(cnt[0]), 16'h0000, "disabled pin");
    chk(16'(cnt[1]), 16'd64, "other pin kept");
    // Idle suspends only when the idle control bit is set
    cpu_idle = 1'b1;
    wr(pwm_pkg::mode_ctrl_addr, 8'h88);
    step(2);
    sfr_wdata = counter_low_byte;
    step(20);
    chk({8'h00, counter_low_byte}, {8'h00, sfr_wdata}, "idle stop");
    wr(pwm_pkg::mode_ctrl_addr, 8'h08);
    step(2);
    sfr_wdata = counter_low_byte;
    step(20);
    chk({8'h00, counter_low_byte}, {8'h00, sfr_wdata + 8'd20}, "idle run");
    cpu_idle = 1'b0;
    // Full 16-bit wrap, then flag, enable and clear
    for (int i = 0; i < 70000 && counter_overflow_flag !== 1'b1; i++) step(1);
    chk({15'h0, counter_overflow_flag}, 16'h0001, "overflow flag");
    chk({15'h0, overflow_irq}, 16'h0000, "irq masked");
    wr(pwm_pkg::mode_ctrl_addr, 8'h09);
    chk({15'h0, overflow_irq}, 16'h0001, "irq enabled");
    overflow_flag_clear = 1'b1;
    step(1);
    overflow_flag_clear = 1'b0;
    step(2);
    chk({14'h0, counter_overflow_flag, overflow_irq}, 16'h0000, "flag cleared");
    // Lock holds the watchdog enable until a new reset
    wr(pwm_pkg::mode_ctrl_addr, 8'h60);
    wr(pwm_pkg::mode_ctrl_addr, 8'h08);
    chk({8'h00, counter_mode_control}, 16'h0068, "lock refuses");
    chk({15'h0, watchdog_active}, 16'h0001, "watchdog kept");
    rst_b = 1'b0;
    step(2);
    rst_b = 1'b1;
    step(1);
    chk({8'h00, counter_mode_control}, 16'h0040, "second reset");
    wr(pwm_pkg::mode_ctrl_addr, 8'h00);
    chk({8'h00, counter_mode_control}, 16'h0000, "unlocked");
    conclude();
  end
endmodule : testbench
